/* verilog/rom_host_pkg.sv */
// Purpose: Constants for the page-mode ROM host read controller.
// Assumes: 250 MHz clock (4 ns period); ROM timing figures in ns.
// Notes:   Cycle counts are derived from the ns figures.
//
// Summary of operation
// [R1] Keep chip select high during and after power-up until the wait ends.
// [R2] Hold chip select high at least 200 ns after power-up before any read.
// [R3] While selected, every address change settles within 10 ns.
// [R4] Address skew limit applies only while chip is selected.
// [R5] Upper and page address bits split at 3 or 4 lowest byte bits.
// [R6] Page-only change gives data in 25 ns; upper change needs 90 ns.
// [R7] Assert output gate before page address bits become stable.
// [R8] Chip select to valid data within 90 ns (85 ns at higher supply).
// [R9] Output gate to valid data within 25 ns with address settled.
// [R10] Outputs float within 25 ns of deselect or gate off; hold 0 ns.
// [R11] Width select change gives new organisation within 90 ns (85 ns).
// [R12] Word mode: shared pin is data bit fifteen.
// [R13] Byte mode: data bits 8 to 14 float; shared pin is lowest address.
// [R14] Width select high means 16-bit words, low means bytes.
// [R15] Output gate polarity fixed: active low, active high or ignored.
package rom_host_pkg;

	// ------------------------------------------------------------
	// Clock and timing figures
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS          = 4;
	localparam int POWERUP_WAIT_NS        = 200;
	localparam int ADDR_ACCESS_NS         = 90;
	localparam int PAGE_ACCESS_NS         = 25;
	localparam int CHIP_ACCESS_NS         = 90;
	localparam int GATE_ACCESS_NS         = 25;
	localparam int OUTPUT_FLOAT_DELAY_NS  = 25;
	localparam int WIDTH_SWITCH_DELAY_NS  = 90;

	// Least times round up to whole cycles; two extra cycles cover pin sync
	localparam int POWERUP_CYC   = (POWERUP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_CYC      = (ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PAGE_CYC      = (PAGE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CHIP_CYC      = (CHIP_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GATE_CYC      = (GATE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLOAT_CYC     = (OUTPUT_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WIDTH_CYC     = (WIDTH_SWITCH_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_CYC      = 2;

	// ------------------------------------------------------------
	// Widths and encodings
	// ------------------------------------------------------------
	localparam int ADDR_W        = 21;   // Byte address incl. lowest byte bit
	localparam int PIN_ADDR_W    = 20;
	localparam int DATA_W        = 16;
	localparam int CNT_W         = 8;

	localparam logic [1:0] GATE_ACTIVE_LOW  = 2'h0;
	localparam logic [1:0] GATE_ACTIVE_HIGH = 2'h1;
	localparam logic [1:0] GATE_IGNORED     = 2'h2;

	typedef enum logic [2:0] {
		ST_POWERUP = 3'h0,
		ST_IDLE    = 3'h1,
		ST_SELECT  = 3'h2,
		ST_WAIT    = 3'h3,
		ST_CAPTURE = 3'h4,
		ST_FLOAT   = 3'h5
	} host_state_t;

endpackage : rom_host_pkg

/* verilog/rom_pin_sync.sv */
// Purpose: Two-flop synchroniser for the ROM data pins.
// Assumes: Data pins are asynchronous to clock_i.
// Notes:   First stage is read only by the second stage.
module rom_pin_sync #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	// Data
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;

	// ------------------------------------------------------------
	// Two stages per bit
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta   <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end

endmodule : rom_pin_sync

/* verilog/rom_host_ctrl.sv */
// Purpose: Host controller reading a page-mode mask ROM through its pins.
// Assumes: One 250 MHz clock; ROM pins are asynchronous and wait-timed.
// Notes:   All ROM timing is met by counting whole cycles, never by sampling.
module rom_host_ctrl
	import rom_host_pkg::*;
#(
	parameter int         PAGE_BITS   = 3,          // 3 for 8-byte, 4 for 16-byte page
	parameter logic [1:0] GATE_OPTION = 2'h0        // Mask-fixed gate polarity
) (
	// Clock and reset
	input  wire logic                            clock_i,
	input  wire logic                            rst_n_i,
	// User request side
	input  wire logic                            req_valid_i,
	output logic                                 req_ready_o,
	input  wire logic [rom_host_pkg::ADDR_W-1:0] req_addr_i,
	input  wire logic                            word_mode_i,
	output logic                                 rsp_valid_o,
	output logic      [rom_host_pkg::DATA_W-1:0] rsp_data_o,
	output logic                                 powerup_done_o,
	// ROM pins
	output logic [rom_host_pkg::PIN_ADDR_W-1:0]  rom_addr_o,
	output logic                                 rom_chip_sel_n_o,
	output logic                                 rom_gate_o,
	output logic                                 rom_word_mode_o,
	input  wire logic [14:0]                     rom_data_i,
	input  wire logic                            data_bit_fifteen_i,
	output logic                                 data_bit_fifteen_o,
	output logic                                 data_bit_fifteen_oe_o
);
	import rom_host_pkg::*;

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (PAGE_BITS != 3 && PAGE_BITS != 4)
		$error("PAGE_BITS must be 3 or 4");
	if (GATE_OPTION != GATE_ACTIVE_LOW && GATE_OPTION != GATE_ACTIVE_HIGH &&
		GATE_OPTION != GATE_IGNORED)
		$error("GATE_OPTION not supported");

	localparam logic [CNT_W-1:0] POWERUP_CNT = CNT_W'(POWERUP_CYC);
	localparam logic [CNT_W-1:0] FULL_CNT    = CNT_W'((CHIP_CYC > ADDR_CYC ? CHIP_CYC : ADDR_CYC)
		+ SYNC_CYC);
	localparam logic [CNT_W-1:0] PAGE_CNT    = CNT_W'((PAGE_CYC > GATE_CYC ? PAGE_CYC : GATE_CYC)
		+ SYNC_CYC);
	localparam logic [CNT_W-1:0] WIDTH_CNT   = CNT_W'(WIDTH_CYC + SYNC_CYC);
	localparam logic [CNT_W-1:0] FLOAT_CNT   = CNT_W'(FLOAT_CYC);

	host_state_t             state;
	logic [CNT_W-1:0]        count;
	logic [ADDR_W-1:0]       cur_addr;
	logic                    addr_open;     // A previous address is still selected
	logic                    mode_reg;
	logic [DATA_W-1:0]       data_sync;
	logic                    page_hit;
	logic                    mode_change;
	logic                    take;
	logic [CNT_W-1:0]        wait_len;      // Cycles of the access now running

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	// Page hit: an address is still selected and only the low page bits differ
	assign page_hit    = addr_open && (req_addr_i[ADDR_W-1:PAGE_BITS]
		== cur_addr[ADDR_W-1:PAGE_BITS]);   // [R5] [R6]
	assign mode_change = word_mode_i != mode_reg;
	assign req_ready_o = (state == ST_IDLE) || (state == ST_CAPTURE);
	assign take        = req_ready_o && req_valid_i;

	// Data pins cross into the clock domain before anything reads them
	rom_pin_sync #(.WIDTH(DATA_W)) data_sync_u (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.async_i ({data_bit_fifteen_i, rom_data_i}),
		.sync_o  (data_sync)
	);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// Chip select stays high from reset until the power-up wait ends
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state <= ST_POWERUP;
			count <= '0;
		end
		else
		begin
			case (state)
				ST_POWERUP:
				begin
					if (count == POWERUP_CNT - 8'h01)  // [R1] [R2]
					begin
						state <= ST_IDLE;
						count <= '0;
					end
					else
						count <= count + 8'h01;
				end
				ST_IDLE, ST_CAPTURE:
				begin
					if (take)
					begin
						state <= ST_WAIT;
						count <= '0;
					end
					else if (state == ST_CAPTURE)
					begin
						state <= ST_FLOAT;
						count <= '0;
					end
				end
				ST_WAIT:
				begin
					if (count == wait_len - 8'h01)
						state <= ST_CAPTURE;
					else
						count <= count + 8'h01;
				end
				ST_FLOAT:
				begin
					// Deselected; wait out the float time before next select
					if (count == FLOAT_CNT - 8'h01)   // [R10]
						state <= ST_IDLE;
					else
						count <= count + 8'h01;
				end
				default:
				begin
					state <= ST_POWERUP;
					count <= '0;
				end
			endcase
		end
	end

	// Wait length chosen when the request is taken
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			wait_len <= '0;
		else if (take)
		begin
			if (mode_change)
				wait_len <= WIDTH_CNT;            // [R11]
			else if (page_hit)
				wait_len <= PAGE_CNT;             // [R6] [R9]
			else
				wait_len <= FULL_CNT;             // [R6] [R8]
		end
	end

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	// Address and mode change only in the same edge that selection begins or
	// continues; flops switch in one edge, far inside the skew limit.
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cur_addr  <= '0;
			mode_reg  <= 1'b1;
			addr_open <= 1'b0;
		end
		else
		begin
			if (take)
			begin
				cur_addr  <= req_addr_i;          // [R3] [R4]
				mode_reg  <= word_mode_i;         // [R14]
				addr_open <= 1'b1;
			end
			else if (state == ST_CAPTURE)
				addr_open <= 1'b0;
		end
	end

	// Chip select and gate: both active from take through capture. The gate
	// goes active together with select, so it is always before page bits settle.
	logic active;
	assign active = (state == ST_WAIT) || (state == ST_CAPTURE);
	always_comb
	begin
		rom_chip_sel_n_o = !active;               // [R1]
		case (GATE_OPTION)
			GATE_ACTIVE_HIGH: rom_gate_o = active;   // [R15] [R7]
			GATE_ACTIVE_LOW:  rom_gate_o = !active;  // [R15] [R7]
			default:          rom_gate_o = 1'b0;
		endcase
	end

	assign rom_addr_o         = cur_addr[ADDR_W-1:1];
	assign rom_word_mode_o    = mode_reg;
	// Shared pin driven as lowest address only in byte mode
	assign data_bit_fifteen_o    = cur_addr[0];       // [R13]
	assign data_bit_fifteen_oe_o = !mode_reg;         // [R12] [R13]

	// ------------------------------------------------------------
	// Answer
	// ------------------------------------------------------------
	// Byte mode keeps only the low byte; the upper pins float then
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rsp_valid_o <= 1'b0;
			rsp_data_o  <= '0;
		end
		else
		begin
			rsp_valid_o <= (state == ST_WAIT) && (count == wait_len - 8'h01);
			if ((state == ST_WAIT) && (count == wait_len - 8'h01))
				rsp_data_o <= mode_reg ? data_sync
					: {8'h00, data_sync[7:0]};  // [R12] [R13]
		end
	end

	// Power-up complete flag
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			powerup_done_o <= 1'b0;
		else if (state != ST_POWERUP)
			powerup_done_o <= 1'b1;
	end

endmodule : rom_host_ctrl

/* testbench/rom_host_ctrl_properties.sv */
// Purpose: Pin timing checks for rom_host_ctrl.
// Assumes: One clock; reset async, active low.
// Notes:   Cycle figures are the controller's own.
module rom_host_ctrl_chk #(
	parameter logic [1:0] GATE_OPTION = 2'h0
) (
	// Clock and requests
	input wire logic        clock_i,
	input wire logic        rst_n_i,
	input wire logic        req_valid_i,
	input wire logic        req_ready_o,
	input wire logic [20:0] req_addr_i,
	input wire logic        word_mode_i,
	input wire logic        rsp_valid_o,
	// ROM pins
	input wire logic [19:0] rom_addr_o,
	input wire logic        rom_chip_sel_n_o,
	input wire logic        rom_gate_o,
	input wire logic        rom_word_mode_o,
	input wire logic        data_bit_fifteen_o,
	input wire logic        data_bit_fifteen_oe_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	logic       take;
	logic [7:0] up_cnt;
	assign take = req_valid_i && req_ready_o;
	// Edges since reset release, parked at the power-up length
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			up_cnt <= 8'h00;
		else if (up_cnt < 8'h32)
			up_cnt <= up_cnt + 8'h01;
	end
	pwr_cs_hold_a: assert property (
		up_cnt < 8'h32 |-> rom_chip_sel_n_o && !req_ready_o) else $error("early select");
	addr_hold_a: assert property (
		!rom_chip_sel_n_o && $past(!rom_chip_sel_n_o) && $changed(rom_addr_o) |-> $past(take))
		else $error("address moved while selected");
	// The answer shows after the edge that ends the wait: 25 quiet samples, then valid
	full_access_a: assert property (
		take && rom_chip_sel_n_o |=> (!rsp_valid_o)[*8] ##1 (!rsp_valid_o)[*8]
		##1 (!rsp_valid_o)[*8] ##1 !rsp_valid_o ##1 rsp_valid_o)
		else $error("full access timing");
	page_window_a: assert property (
		take |=> (!rsp_valid_o)[*8] ##[1:18] rsp_valid_o) else $error("answer out of window");
	gate_on_a: assert property (
		!rom_chip_sel_n_o |-> rom_gate_o == (GATE_OPTION == 2'h1)) else $error("gate level");
	pin_dir_a: assert property (
		rom_word_mode_o != data_bit_fifteen_oe_o) else $error("shared pin direction");
	req_latch_a: assert property (
		take |=> {1'b0, rom_addr_o} == ($past(req_addr_i) >> 1)
		&& rom_word_mode_o == $past(word_mode_i)
		&& (rom_word_mode_o || {20'h0, data_bit_fifteen_o} == ($past(req_addr_i) & 21'h1)))
		else $error("request pins");
	float_gap_a: assert property (
		$rose(rom_chip_sel_n_o) |-> (!req_ready_o)[*7]) else $error("float gap short");
endmodule : rom_host_ctrl_chk
bind rom_host_ctrl rom_host_ctrl_chk #(.GATE_OPTION(GATE_OPTION)) rom_host_ctrl_chk_inst (
	.clock_i, .rst_n_i, .req_valid_i, .req_ready_o, .req_addr_i, .word_mode_i, .rsp_valid_o,
	.rom_addr_o, .rom_chip_sel_n_o, .rom_gate_o, .rom_word_mode_o, .data_bit_fifteen_o,
	.data_bit_fifteen_oe_o);

/* testbench/rom_page_model.sv */
// Purpose: Behavioural page-mode ROM facing the host controller.
// Assumes: Delays in ns; contents scramble the word address.
// Notes:   Released pins show the inverse of the last word.
module rom_page_model #(
	parameter int         PAGE_BITS   = 3,
	parameter logic [1:0] GATE_OPTION = 2'h0
) (
	// Host pins
	input  wire logic [19:0] addr_i,
	input  wire logic        chip_sel_n_i,
	input  wire logic        gate_i,
	input  wire logic        word_mode_i,
	input  wire logic        lsb_pin_i,
	// Data pins
	output logic      [14:0] data_o,
	output logic             bit15_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] word_q = '0;
	logic [15:0] next_word;
	logic [22:0] key_q = '1;
	logic [20:0] up_q;
	logic        on;
	realtime     due = 0;
	realtime     up_since = 0;
	// Fixed image
	function automatic logic [15:0] word_at(input logic [19:0] a);
		return {a[7:0], a[15:8]} ^ {a[19:16], 12'h9E1};
	endfunction : word_at
	// Select, width or upper bits moving restart the full access; page bits alone
	// give the page time, yet never earlier than the full time since the last move
	always @(addr_i or chip_sel_n_i or word_mode_i or lsb_pin_i)
	begin : access
		logic [20:0] fa;
		fa = {addr_i, word_mode_i ? 1'b0 : lsb_pin_i};
		if ({chip_sel_n_i, word_mode_i, fa} != key_q)
		begin
			if (key_q[22] || chip_sel_n_i || key_q[21] != word_mode_i
				|| (fa >> PAGE_BITS) != up_q)
				up_since = $realtime;
			due = (up_since + 90 > $realtime + 25) ? up_since + 90 : $realtime + 25;
			key_q = {chip_sel_n_i, word_mode_i, fa};
			up_q = fa >> PAGE_BITS;
			word_q = ~word_q; // Junk while the array settles
			next_word = word_at(fa[20:1]);
			if (!word_mode_i)
				next_word = {8'h00, fa[0] ? next_word[15:8] : next_word[7:0]};
		end
	end
	// A newer change has already pushed due further out
	always #1
		if ($realtime >= due && !chip_sel_n_i)
			word_q = next_word;
	// Drive only while selected and gated
	assign on = !chip_sel_n_i && (GATE_OPTION == 2'h2 || gate_i == GATE_OPTION[0]);
	assign data_o[7:0] = on ? word_q[7:0] : ~word_q[7:0];
	assign data_o[14:8] = (on && word_mode_i) ? word_q[14:8] : ~word_q[14:8];
	assign bit15_o = (on && word_mode_i) ? word_q[15] : ~word_q[15];
endmodule : rom_page_model

/* testbench/testbench.sv */
// Purpose: Self-checking bench for the ROM host controller.
// Assumes: 250 MHz clock; page size of eight bytes.
// Notes:   Driver queues notes; a monitor pops one per answer.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {
		logic [15:0] data;
		int          at;
	} note_t;
	logic        clock_i, rst_n_i, req_valid_i, req_ready_o, word_mode_i, rsp_valid_o;
	logic        cs_n, gate, rmode, b15_o, b15_oe, b15_m, pin, last_mode, pwr_done;
	logic [20:0] req_addr_i, last_up;
	logic [19:0] rom_addr_o;
	logic [15:0] rsp_data_o;
	logic [14:0] rom_data;
	note_t       notes[$];
	int          error_cnt, n_tests, cyc;
	assign pin = b15_oe ? b15_o : b15_m; // Shared pin follows its driver
	rom_host_ctrl #(.PAGE_BITS(3), .GATE_OPTION(2'h1)) rom_host_ctrl_inst (
		.clock_i, .rst_n_i, .req_valid_i, .req_ready_o, .req_addr_i, .word_mode_i,
		.rsp_valid_o, .rsp_data_o, .powerup_done_o(pwr_done), .rom_addr_o, .rom_chip_sel_n_o(cs_n),
		.rom_gate_o(gate), .rom_word_mode_o(rmode), .rom_data_i(rom_data),
		.data_bit_fifteen_i(pin), .data_bit_fifteen_o(b15_o), .data_bit_fifteen_oe_o(b15_oe));
	rom_page_model #(.PAGE_BITS(3), .GATE_OPTION(2'h1)) rom_page_model_inst (
		.addr_i(rom_addr_o), .chip_sel_n_i(cs_n), .gate_i(gate), .word_mode_i(rmode),
		.lsb_pin_i(pin), .data_o(rom_data), .bit15_o(b15_m));
	initial
	begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t: saw %0h, expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	// Hold a request until taken; a request still valid from before is a page try
	task automatic read(input logic [20:0] a, input logic m);
		logic [15:0] w;
		int          lat;
		int          n;
		w = rom_page_model_inst.word_at(a[20:1]);
		lat = (req_valid_i && m == last_mode && (a >> 3) == last_up) ? 9 : 25;
		n = 0;
		@(posedge clock_i);
		#1;
		req_valid_i = 1'b1;
		req_addr_i = a;
		word_mode_i = m;
		do
		begin
			@(negedge clock_i);
			n++;
		end while (req_ready_o !== 1'b1 && n < 100);
		if (n >= 100)
		begin
			check(32'h0, 32'h1); // Hung
			results();
		end
		@(posedge clock_i);
		// The answer shows after the wait's last edge, so the monitor meets it one tick later
		notes.push_back('{m ? w : {8'h00, a[0] ? w[15:8] : w[7:0]}, cyc + lat + 1});
		last_up = a >> 3;
		last_mode = m;
	endtask : read
	// Answers checked against the oldest note
	initial
	begin
		cyc = 0;
		forever
		begin
			@(negedge clock_i);
			cyc++;
			if (rsp_valid_o === 1'b1 && notes.size() == 0)
				check(32'h0, 32'h1); // Unasked answer
			else if (rsp_valid_o === 1'b1)
			begin
				check({16'h0, rsp_data_o}, {16'h0, notes[0].data});
				check(cyc, notes[0].at);
				notes.delete(0);
			end
		end
	end
	// Bursts of page reads, a page crossing and a width switch
	initial
	begin
		logic [20:0] base;
		{rst_n_i, req_valid_i, word_mode_i, last_mode} = 4'h2;
		req_addr_i = '0;
		last_up = '0;
		error_cnt = 0;
		n_tests = 0;
		void'($urandom(81225));
		repeat (5) @(posedge clock_i);
		#1 rst_n_i = 1'b1;
		// 200 ns is fifty clocks: no ready and no done flag before they have passed
		repeat (50) @(negedge clock_i);
		check({31'h0, req_ready_o}, 32'h0);
		check({31'h0, pwr_done}, 32'h0);
		@(negedge clock_i);
		check({31'h0, req_ready_o}, 32'h1);
		for (int k = 0; k < 8; k++)
		begin
			base = 21'($urandom);
			for (int j = 0; j < 4; j++)
				read((base & ~21'h7) | 21'($urandom % 8), k[0]);
			read(base + 21'h8, k[0]);
			read(base + 21'h8, !k[0]);
			#1 req_valid_i = 1'b0;
		end
		for (int n = 0; n < 100 && notes.size() > 0; n++)
			@(posedge clock_i);
		check(32'(notes.size()), 32'h0);
		check({31'h0, pwr_done}, 32'h1);
		results();
	end
endmodule : testbench
